// File: rtl/rail_seq_regs.svh
/*
 * Register offsets, field positions, reset and default values and timing
 * figures of the rail sequencer.
 * Assumes inclusion by bare name from the package; the modules see its macros from there.
 */
`ifndef RAIL_SEQ_REGS_SVH
`define RAIL_SEQ_REGS_SVH

`define RAIL_CNT          4
// register byte offsets on the serial interface
`define CTRL_BASE         8'h02
`define VOUT_BASE         8'h0a
`define DELAY_BASE        8'h12
`define STATUS_ADDR       8'h20
// control register fields
`define CTRL_I2C_ON       0
`define CTRL_PIN_CTRL     1
`define CTRL_ILIM_LSB     2
`define CTRL_SLEW_LSB     5
// delay register fields
`define DLY_OFF_MSB       7
`define DLY_OFF_LSB       4
`define DLY_ON_MSB        3
`define DLY_ON_LSB        0
`define DLY_RESET         4'h0
// one-time-programmable defaults, per rail 3..0 except ILIM and SLEW; delays in milliseconds
`define OTP_ON_DLY        {4'h5, 4'h5, 4'h0, 4'h0}
`define OTP_OFF_DLY       {4'h0, 4'h0, 4'h5, 4'h5}
`define OTP_VOUT          {8'h50, 8'h8c, 8'hc8, 8'h28}
`define OTP_ILIM          3'h5
`define OTP_SLEW          3'h2
// timebase
`define CLK_MHZ           25
`define MS_PERIOD_US      1000
`define MS_CYCLES         (`MS_PERIOD_US * `CLK_MHZ)
// serial interface
`define I2C_BITS          4'h8
`define DEV_ADDR          7'h60

`endif

// File: rtl/rail_seq_pkg.sv
/*
 * Types shared by the rail sequencer modules.
 * Assumes rail_seq_regs.svh is on the include path.
 */
package rail_seq_pkg;
`include "rail_seq_regs.svh"

    typedef struct packed {
        logic [7:0] vout;
        logic [2:0] slew;
        logic [2:0] ilim;
        logic       pin_ctrl;
        logic       i2c_on;
        logic [3:0] off_delay;
        logic [3:0] on_delay;
    } rail_cfg_s;

    typedef enum logic [1:0] {
        SEQ_POR,
        SEQ_OTP,
        SEQ_IFEN,
        SEQ_STBY
    } seq_state_e;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_AACK,
        I2C_PTR,
        I2C_PACK,
        I2C_WR,
        I2C_RD,
        I2C_RACK
    } i2c_state_e;

endpackage : rail_seq_pkg

// File: rtl/rail_delay_timer.sv
/*
 * One rail's enable timing: a millisecond delay counter restarted on
 * every edge of the synchronised enable input that arrives while the top is in standby.
 * Assumes edge pulses come from logic on the same clock.
 */
module rail_delay_timer
    import rail_seq_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input  wire logic      clk_i,
    input  wire logic      rstn_i,
    input  wire logic      en_rise_i,
    input  wire logic      en_fall_i,
    input  wire rail_cfg_s cfg_i,
    output logic           rail_on_o
);
    localparam int CW = $clog2(MS_CYCLES);

    logic          pend_ff;
    logic          tgt_ff;
    logic          pin_on_ff;
    logic [3:0]    ms_ff;
    logic [CW-1:0] cyc_ff;
    logic          rail_on_ff;

    wire ms_done  = (cyc_ff == CW'(MS_CYCLES - 1));
    wire expire   = pend_ff && (ms_ff == 4'h0);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_ff   <= 1'b0;
            tgt_ff    <= 1'b0;
            pin_on_ff <= 1'b0;
            ms_ff     <= 4'h0;
            cyc_ff    <= '0;
        end else if (en_rise_i || en_fall_i) begin
            // a new edge cancels whatever was pending
            pend_ff <= 1'b1;
            tgt_ff  <= en_rise_i;
            ms_ff   <= en_rise_i ? cfg_i.on_delay : cfg_i.off_delay;
            cyc_ff  <= '0;
        end else if (expire) begin
            pend_ff   <= 1'b0;
            pin_on_ff <= tgt_ff;
        end else if (pend_ff) begin
            // linear decode: one count per millisecond
            if (ms_done) begin
                cyc_ff <= '0;
                ms_ff  <= ms_ff - 4'h1;
            end else begin
                cyc_ff <= cyc_ff + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rail_on_ff <= 1'b0;
        end else begin
            rail_on_ff <= cfg_i.i2c_on | (cfg_i.pin_ctrl & pin_on_ff);
        end
    end

    assign rail_on_o = rail_on_ff;

endmodule : rail_delay_timer

// File: rtl/rail_enable_delay_sequencer.sv
/*
 * Digital sequencer of a four-rail step-down regulator: release
 * sequencing, per-rail settings over an I2C slave, and enable delays.
 * Assumes rail_enable_input, device_release_n, scl and sda come from pins
 * and the open-drain sda wire is resolved outside from sda_oe_o.
 */
module rail_enable_delay_sequencer
    import rail_seq_pkg::*;
#(
    parameter int         MS_CYCLES = `MS_CYCLES,
    parameter logic [6:0] DEV_ADDR  = `DEV_ADDR   // arbitrary value
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 device_release_n_i,
    input  wire logic                 rail_enable_input_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output logic                      standby_o,
    output logic [`RAIL_CNT-1:0]      rail_on_o
);
    localparam int N = `RAIL_CNT;

    // pins: 0 release, 1 enable, 2 scl, 3 sda; release resets to held
    // so a pin held low at reset never fakes a release
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_ff <= 4'hc;
            sync2_ff <= 4'hc;
            prev_ff  <= 4'hc;
        end else begin
            sync1_ff <= {sda_i, scl_i, rail_enable_input_i,
                         device_release_n_i};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    wire released  = sync2_ff[0];
    wire en_rise   = sync2_ff[1] & ~prev_ff[1];
    wire en_fall   = ~sync2_ff[1] & prev_ff[1];
    wire scl_rise  = sync2_ff[2] & ~prev_ff[2];
    wire scl_fall  = ~sync2_ff[2] & prev_ff[2];
    wire sda_now   = sync2_ff[3];
    wire i2c_start = sync2_ff[2] & prev_ff[2] & ~sda_now & prev_ff[3];
    wire i2c_stop  = sync2_ff[2] & prev_ff[2] & sda_now & ~prev_ff[3];

    // release sequencing
    seq_state_e seq_ff;
    seq_state_e nxt_seq;

    always_comb begin
        case (seq_ff)
            SEQ_POR:  nxt_seq = released ? SEQ_OTP : SEQ_POR;
            SEQ_OTP:  nxt_seq = SEQ_IFEN;
            SEQ_IFEN: nxt_seq = SEQ_STBY;
            SEQ_STBY: nxt_seq = SEQ_STBY;
            default:  nxt_seq = SEQ_POR;
        endcase
        if (!released) begin
            nxt_seq = SEQ_POR;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_ff <= SEQ_POR;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    wire otp_load = (seq_ff == SEQ_OTP);
    wire if_on    = (seq_ff == SEQ_STBY);

    // settings
    rail_cfg_s  cfg_ff [N];
    logic [7:0] ptr_ff;
    logic [7:0] sh_ff;
    logic       wr_stb;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (a == `CTRL_BASE + 8'(i)) begin
                d = {cfg_ff[i].slew, cfg_ff[i].ilim,
                     cfg_ff[i].pin_ctrl, cfg_ff[i].i2c_on};
            end
            if (a == `VOUT_BASE + 8'(i)) begin
                d = cfg_ff[i].vout;
            end
            if (a == `DELAY_BASE + 8'(i)) begin
                d = {cfg_ff[i].off_delay, cfg_ff[i].on_delay};
            end
        end
        if (a == `STATUS_ADDR) begin
            d = {2'b00, seq_ff, rail_on_o};
        end
        return d;
    endfunction : reg_read

    logic [N-1:0] rail_on;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_rail
            wire wr_ctrl = wr_stb && (ptr_ff == `CTRL_BASE + 8'(g));
            wire wr_vout = wr_stb && (ptr_ff == `VOUT_BASE + 8'(g));
            wire wr_dly  = wr_stb && (ptr_ff == `DELAY_BASE + 8'(g));

            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cfg_ff[g]           <= '0;
                    cfg_ff[g].on_delay  <= `DLY_RESET;
                    cfg_ff[g].off_delay <= `DLY_RESET;
                end else if (otp_load) begin
                    cfg_ff[g].on_delay  <= 4'(`OTP_ON_DLY >> (4*g));
                    cfg_ff[g].off_delay <= 4'(`OTP_OFF_DLY >> (4*g));
                    cfg_ff[g].vout      <= 8'(`OTP_VOUT >> (8*g));
                    cfg_ff[g].ilim      <= `OTP_ILIM;
                    cfg_ff[g].slew      <= `OTP_SLEW;
                    cfg_ff[g].pin_ctrl  <= 1'b1;
                    cfg_ff[g].i2c_on    <= 1'b0;
                end else if (wr_ctrl) begin
                    // each rail decodes only its own offsets
                    cfg_ff[g].i2c_on   <= sh_ff[`CTRL_I2C_ON];
                    cfg_ff[g].pin_ctrl <= sh_ff[`CTRL_PIN_CTRL];
                    cfg_ff[g].ilim <= sh_ff[`CTRL_ILIM_LSB +: 3];
                    cfg_ff[g].slew <= sh_ff[`CTRL_SLEW_LSB +: 3];
                end else if (wr_vout) begin
                    cfg_ff[g].vout <= sh_ff;
                end else if (wr_dly) begin
                    cfg_ff[g].off_delay <=
                        sh_ff[`DLY_OFF_MSB:`DLY_OFF_LSB];
                    cfg_ff[g].on_delay  <= sh_ff[`DLY_ON_MSB:`DLY_ON_LSB];
                end
            end

            rail_delay_timer #(
                .MS_CYCLES (MS_CYCLES)
            ) u_timer (
                .clk_i     (clk_i),
                .rstn_i    (rstn_i),
                .en_rise_i (en_rise && if_on),
                .en_fall_i (en_fall && if_on),
                .cfg_i     (cfg_ff[g]),
                .rail_on_o (rail_on[g])
            );
        end
    endgenerate

    // serial slave; bus ignored until the interface is enabled
    i2c_state_e st_ff;
    logic [3:0] cnt_ff;
    logic       rw_ff;
    logic       nack_ff;
    logic       oe_ff;
    logic       stby_ff;

    wire [7:0] next_ptr = ptr_ff + 8'h01;
    wire       byte_in  = (cnt_ff == `I2C_BITS);
    assign wr_stb = if_on && scl_fall && (st_ff == I2C_WR) && byte_in;
    logic [7:0] rd_now;
    logic [7:0] rd_next;

    // always_comb, unlike an assign, follows registers read by the function
    always_comb begin
        rd_now  = reg_read(ptr_ff);
        rd_next = reg_read(next_ptr);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff   <= I2C_IDLE;
            cnt_ff  <= 4'h0;
            rw_ff   <= 1'b0;
            nack_ff <= 1'b0;
            oe_ff   <= 1'b0;
            ptr_ff  <= 8'h00;
            sh_ff   <= 8'h00;
        end else if (!if_on || i2c_stop) begin
            st_ff <= I2C_IDLE;
            oe_ff <= 1'b0;
        end else if (i2c_start) begin
            st_ff  <= I2C_ADDR;
            cnt_ff <= 4'h0;
            oe_ff  <= 1'b0;
        end else if (scl_rise) begin
            if (st_ff == I2C_RACK) begin
                nack_ff <= sda_now;
            end else if (st_ff != I2C_RD) begin
                sh_ff <= {sh_ff[6:0], sda_now};
            end
            cnt_ff <= cnt_ff + 4'h1;
        end else if (scl_fall) begin
            case (st_ff)
                I2C_ADDR: begin
                    if (byte_in && sh_ff[7:1] == DEV_ADDR) begin
                        oe_ff <= 1'b1;
                        rw_ff <= sh_ff[0];
                        st_ff <= I2C_AACK;
                    end else if (byte_in) begin
                        st_ff <= I2C_IDLE;
                    end
                end
                I2C_AACK: begin
                    cnt_ff <= 4'h0;
                    if (rw_ff) begin
                        sh_ff <= rd_now;
                        oe_ff <= ~rd_now[7];
                        st_ff <= I2C_RD;
                    end else begin
                        oe_ff <= 1'b0;
                        st_ff <= I2C_PTR;
                    end
                end
                I2C_PTR: begin
                    if (byte_in) begin
                        ptr_ff <= sh_ff;
                        oe_ff  <= 1'b1;
                        st_ff  <= I2C_PACK;
                    end
                end
                I2C_PACK, I2C_WR: begin
                    // acknowledge of pointer or data byte ends here
                    if (st_ff == I2C_PACK || !byte_in) begin
                        oe_ff  <= 1'b0;
                        cnt_ff <= (st_ff == I2C_PACK) ? 4'h0 : cnt_ff;
                        st_ff  <= I2C_WR;
                    end else begin
                        ptr_ff <= next_ptr;
                        oe_ff  <= 1'b1;
                        st_ff  <= I2C_PACK;
                    end
                end
                I2C_RD: begin
                    if (byte_in) begin
                        oe_ff <= 1'b0;
                        st_ff <= I2C_RACK;
                    end else begin
                        oe_ff <= ~sh_ff[3'(4'h7 - cnt_ff)];
                    end
                end
                I2C_RACK: begin
                    if (nack_ff) begin
                        st_ff <= I2C_IDLE;
                    end else begin
                        ptr_ff <= next_ptr;
                        sh_ff  <= rd_next;
                        oe_ff  <= ~rd_next[7];
                        cnt_ff <= 4'h0;
                        st_ff  <= I2C_RD;
                    end
                end
                default: st_ff <= I2C_IDLE;
            endcase
        end
    end

    logic [N-1:0] rail_on_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stby_ff    <= 1'b0;
            rail_on_ff <= '0;
        end else begin
            stby_ff    <= if_on;
            rail_on_ff <= rail_on;
        end
    end

    // open drain: the wire is only ever pulled low
    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_ff;
    assign standby_o = stby_ff;
    assign rail_on_o = rail_on_ff;

endmodule : rail_enable_delay_sequencer

// File: bench/rail_enable_delay_sequencer_props.sv
/*
 * Port checker of the rail sequencer, bound to every instance.
 * Assumes one clock domain and an I2C clock of 8 or more clocks a phase.
 */
module rail_seq_props #(
    parameter int MS_CYCLES = 25000
) (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       device_release_n_i,
    input wire logic       rail_enable_input_i,
    input wire logic       scl_i,
    input wire logic       sda_oe_o,
    input wire logic       standby_o,
    input wire logic [3:0] rail_on_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // longest delay plus sync and output stages
    localparam int LIM = 15 * MS_CYCLES + 12;

    logic        en_q_ff;
    logic        scl_q_ff;
    logic        rel_q_ff;
    logic [31:0] quiet_ff;
    logic [31:0] nxt_quiet;
    wire         moved = (rail_enable_input_i != en_q_ff)
                       | (scl_i != scl_q_ff)
                       | (device_release_n_i != rel_q_ff);

    assign nxt_quiet = moved ? 32'h0
                     : (quiet_ff < LIM) ? quiet_ff + 32'h1 : quiet_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_q_ff  <= 1'b0;
            scl_q_ff <= 1'b1;
            rel_q_ff <= 1'b0;
            quiet_ff <= 32'h0;
        end else begin
            en_q_ff  <= rail_enable_input_i;
            scl_q_ff <= scl_i;
            rel_q_ff <= device_release_n_i;
            quiet_ff <= nxt_quiet;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_oe_needs_standby: assert property (
        !standby_o && !$past(standby_o) |-> !sda_oe_o)
        else $error("data line pulled outside standby");
    a_standby_entry: assert property (
        device_release_n_i [*8] |=> standby_o)
        else $error("standby not reached after release");
    a_standby_exit: assert property (
        !device_release_n_i [*5] |=> !standby_o)
        else $error("standby kept while held");
    a_standby_holds: assert property (
        device_release_n_i [*4] ##0 standby_o |=> standby_o)
        else $error("standby dropped while released");
    a_ack_holds: assert property (
        $rose(sda_oe_o) |=> sda_oe_o [*8])
        else $error("acknowledge too short");
    a_oe_scl_low: assert property (
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("data line moved while clock high");
    a_edge_no_jump: assert property (
        $changed(rail_enable_input_i) |=> $stable(rail_on_o) [*2])
        else $error("rail moved before enable was synchronised");
    a_rails_settle: assert property (
        quiet_ff == LIM |-> $stable(rail_on_o))
        else $error("rail moved long after last cause");

    cover property ($rose(standby_o));
    cover property ($rose(sda_oe_o));
    cover property ($fell(rail_on_o[0]));
    cover property ($rose(rail_on_o[3]));
endmodule : rail_seq_props

bind rail_enable_delay_sequencer rail_seq_props #(
    .MS_CYCLES (MS_CYCLES)
) i_props (
    .clk_i               (clk_i),
    .rstn_i              (rstn_i),
    .device_release_n_i  (device_release_n_i),
    .rail_enable_input_i (rail_enable_input_i),
    .scl_i               (scl_i),
    .sda_oe_o            (sda_oe_o),
    .standby_o           (standby_o),
    .rail_on_o           (rail_on_o)
);

// File: bench/i2c_host_model.sv
/*
 * I2C host model: byte-wide register writes and reads.
 * Assumes a pull-up on the data wire; calls start just after a clock edge.
 */
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h60
) (
    input  wire logic clk_i,
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_low = 1'b0;
    // pull-up: the wire is low while either party pulls
    assign sda_o = ~(host_low | dev_oe_i);
    initial scl_o = 1'b1;

    // third of a bit, ten clocks, slow enough for the pin synchronisers
    task automatic hq();
        repeat (10) @(posedge clk_i);
        #1;
    endtask : hq

    task automatic bit_x(input logic b, output logic s);
        host_low = ~b;
        hq();
        scl_o = 1'b1;
        hq();
        s = sda_o;
        scl_o = 1'b0;
        hq();
    endtask : bit_x

    // ninth bit sent high: reads end with a not-acknowledge
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                          output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(1'b1, s);
        ack = ~s;
    endtask : byte_x

    task automatic start();
        host_low = 1'b0;
        hq();
        scl_o = 1'b1;
        hq();
        host_low = 1'b1;
        hq();
        scl_o = 1'b0;
        hq();
    endtask : start

    task automatic stop();
        host_low = 1'b1;
        hq();
        scl_o = 1'b1;
        hq();
        host_low = 1'b0;
        hq();
    endtask : stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       k1, k2, k3;
        start();
        byte_x({DEV_ADDR, 1'b0}, q, k1);
        byte_x(a, q, k2);
        byte_x(d, q, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       k1, k2, k3, k4;
        start();
        byte_x({DEV_ADDR, 1'b0}, q, k1);
        byte_x(a, q, k2);
        start();
        byte_x({DEV_ADDR, 1'b1}, q, k3);
        byte_x(8'hff, d, k4);
        stop();
        ok = k1 & k2 & k3;
    endtask : rd
endmodule : i2c_host_model

// File: bench/rail_enable_delay_sequencer_tb.sv
/*
 * Self-checking bench of the rail sequencer with an I2C host model.
 * Assumes the millisecond count is shortened to ten clocks.
 */
module rail_enable_delay_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         MS  = 10;
    localparam logic [6:0] DEV = 7'h60;  // arbitrary value
    localparam logic [7:0] DEF [4] = '{8'h50, 8'h50, 8'h05, 8'h05};
    logic       clk_i  = 1'b0;
    logic       rstn_i = 1'b0;
    logic       rel_n  = 1'b0;
    logic       en     = 1'b0;
    logic       scl, sda, sda_oe, stby, sda_lvl;
    logic [3:0] rail;
    int         errors = 0;
    int         comparisons = 0;

    always #20 clk_i = ~clk_i;

    rail_enable_delay_sequencer #(.MS_CYCLES(MS), .DEV_ADDR(DEV)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .device_release_n_i(rel_n),
        .rail_enable_input_i(en), .scl_i(scl), .sda_i(sda), .sda_o(sda_lvl),
        .sda_oe_o(sda_oe), .standby_o(stby), .rail_on_o(rail));
    i2c_host_model #(.DEV_ADDR(DEV)) i_host (
        .clk_i(clk_i), .dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i_host.wr(a, d, ok);
        chk(32'(ok), 32'h1);
    endtask : wr_chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic       ok;
        logic [7:0] q;
        i_host.rd(a, q, ok);
        chk({23'h0, ok, q}, {24'h1, exp});
    endtask : rd_chk

    task automatic release_dev();
        rel_n = 1'b1;
        tick(12);
        chk(32'(stby), 32'h1);
        tick(17500);
    endtask : release_dev

    // first cycle each rail reaches lvl must sit in the delay window
    task automatic edge_chk(input logic lvl, input logic [15:0] dl);
        int t[4];
        int lo;
        t = '{-1, -1, -1, -1};
        en = lvl;
        for (int c = 0; c < 200; c++) begin
            tick(1);
            for (int i = 0; i < 4; i++) begin
                if (t[i] < 0 && rail[i] === lvl) begin
                    t[i] = c;
                end
            end
        end
        for (int i = 0; i < 4; i++) begin
            lo = int'(dl[i*4+:4]) * MS + 2;
            chk(32'(t[i] >= lo && t[i] <= lo + 7), 32'h1);
        end
    endtask : edge_chk

    initial begin
        logic ok;
        int   hi;
        tick(12);
        rstn_i = 1'b1;
        i_host.wr(8'h12, 8'h00, ok);
        chk(32'(ok), 32'h0);
        chk(32'(stby), 32'h0);
        $display("test refused done");
        release_dev();
        for (int i = 0; i < 4; i++) rd_chk(8'h12 + 8'(i), DEF[i]);
        rd_chk(8'h02, 8'h56);
        rd_chk(8'h0a, 8'h28);
        rd_chk(8'h0d, 8'h50);
        rd_chk(8'h30, 8'h00);
        $display("test defaults done");
        edge_chk(1'b1, 16'h5500);
        edge_chk(1'b0, 16'h0055);
        wr_chk(8'h12, 8'hf3);
        rd_chk(8'h12, 8'hf3);
        rd_chk(8'h13, 8'h50);
        edge_chk(1'b1, 16'h5503);
        edge_chk(1'b0, 16'h005f);
        $display("test delays done");
        hi = 0;
        en = 1'b1;
        tick(10);
        en = 1'b0;
        repeat (80) begin
            tick(1);
            if (rail[0] !== 1'b0) hi++;
        end
        chk(32'(hi), 32'h0);
        tick(200);
        $display("test cancel done");
        wr_chk(8'h02, 8'h57);
        tick(10);
        chk(32'(rail), 32'h1);
        rd_chk(8'h20, 8'h31);
        chk(32'(sda_lvl), 32'h0);
        rd_chk(8'h03, 8'h56);
        wr_chk(8'h02, 8'h56);
        tick(10);
        chk(32'(rail), 32'h0);
        $display("test command done");
        rel_n = 1'b0;
        tick(8);
        chk(32'(stby), 32'h0);
        release_dev();
        rd_chk(8'h12, 8'h50);
        $display("test reload done");
        end_sim();
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule : rail_enable_delay_sequencer_tb
